/* core/psq_sequencer.sv */
// Pressure sensor measurement sequencer with its serial target port.
// Expects scl/sda pin levels from outside the clock domain, ADC words valid
// at the end of each conversion phase, and static mode and rate inputs.
//
// Overview of operation
// - Start then stop with no clock pulses makes the next transaction fail.
// - Repeated start inside a transfer makes the next transaction fail likewise.
// - Two modes: periodic update, or measurement only on controller request.
// - After reset wait 1.5 ms, then temperature, auto-zero and bridge conversions.
// - In periodic mode first result lands within 2.8 ms.
// - Rate 0 runs back to back; other rates power down after each write.
// - Rates 0-3 give 0.5/1.5/6.5/32 ms and 255/127/31/15 special gaps.
// - Rate 0 has no power-down; listed periods are typical, worst 1.5x.
// - Special measurement is followed by bridge, lengthening that period one conversion.
// - In periodic mode a completed read marks the status stale.
// - On-request mode powers down after the first measurement until a request arrives.
// - Read-type request measures temperature, auto-zero and pressure, then corrects.
// - Write-type request measures pressure only, using stored temperature and zero.
// - After a requested measurement write results, then power down again.
// - A fetch wakes the device only if it read a stale or fault status while powered down; afterwards the status turns stale.
// - A fetch during a requested measurement cycle returns the stale code.
// - Request response typically 1.3 ms read-type, 0.5 ms write-type.
// - Output data invalid from reset until the first result is written; the status reads stale (10) meanwhile.
// - Write-type request first after reset still reports valid status.
// - Status 00 fresh, 01 invalid, 10 stale, 11 diagnostic fault.
// - Fetch sends two bridge bytes with status on top, then temperature bytes.
module psq_sequencer
   import psq_pkg::*;
#(
   parameter int INIT_CYC = INIT_CYCLES,
   parameter int SPECIAL_CYC = SPECIAL_CYCLES,
   parameter int BRIDGE_CYC = BRIDGE_CYCLES,
   parameter int SLEEP1_CYC = SLEEP1_CYCLES,
   parameter int SLEEP2_CYC = SLEEP2_CYCLES,
   parameter int SLEEP3_CYC = SLEEP3_CYCLES,
   parameter int FIRST_RESULT_CYC = FIRST_RESULT_CYCLES,
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
   input wire logic clk, // Core clock
   input wire logic rst, // Asynchronous reset
   input wire logic scl_i, // Serial clock pin level
   input wire logic sda_i, // Serial data pin level
   output logic sda_o, // Serial data drive value
   output logic sda_oe_n, // Low while pulling data low
   input wire logic sleep_mode, // 1 selects measurement on request
   input wire logic [1:0] rate_sel, // Update rate code
   input wire logic diag_fault, // Diagnostic fault seen
   input wire logic [13:0] adc_bridge, // Bridge conversion word
   input wire logic [10:0] adc_temp, // Temperature conversion word
   input wire logic [13:0] adc_zero, // Auto-zero conversion word
   output logic conv_special, // Temperature and zero phase
   output logic conv_bridge, // Bridge phase
   output logic powered_down, // Analog section off
   output logic result_written, // Output register updated
   output logic result_fresh // Unread result held
);
   // ************************************************
   // Helpers
   // ************************************************
   function automatic logic [31:0] sleep_len(input logic [1:0] rate);
      case (rate)
         2'h1: sleep_len = 32'(SLEEP1_CYC - 1);
         2'h2: sleep_len = 32'(SLEEP2_CYC - 1);
         default: sleep_len = 32'(SLEEP3_CYC - 1);
      endcase
   endfunction

   function automatic logic [7:0] special_gap(input logic [1:0] rate);
      case (rate)
         2'h0: special_gap = GAP_RATE0;
         2'h1: special_gap = GAP_RATE1;
         2'h2: special_gap = GAP_RATE2;
         default: special_gap = GAP_RATE3;
      endcase
   endfunction

   psq_seq_t seq_reg;
   psq_i2c_t ic_reg;
   logic [31:0] cnt_reg;
   logic [7:0] gap_reg;
   logic due_reg;
   logic [13:0] zero_reg;
   logic [10:0] temp_reg;
   logic [13:0] out_bridge_reg;
   logic [10:0] out_temp_reg;
   logic fresh_reg;
   logic req_full_reg;
   logic req_press_reg;
   logic fetch_done_reg;
   logic [2:0] scl_s_reg;
   logic [2:0] sda_s_reg;
   logic scl_f_reg;
   logic sda_f_reg;
   logic scl_p_reg;
   logic sda_p_reg;
   logic [3:0] bit_reg;
   logic [7:0] rx_reg;
   logic rw_reg;
   logic hit_reg;
   logic sent_reg;
   logic stale_pkt_reg;
   logic poison_reg;
   logic seen_reg;
   logic drive_reg;
   psq_packet_t tx_reg;
   logic phase_done;
   logic wake;
   logic [1:0] status_now;
   logic start_ev;
   logic stop_ev;
   logic scl_rise;
   logic scl_fall;

   assign phase_done = (cnt_reg == 32'h0);
   assign wake = sleep_mode && (seq_reg == SQ_IDLE) && (req_full_reg || req_press_reg);

   // ************************************************
   // Measurement sequencer
   // ************************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         seq_reg <= SQ_INIT;
         cnt_reg <= 32'(INIT_CYC - 1);
         gap_reg <= 8'h00;
         due_reg <= 1'b0;
         result_written <= 1'b0;
      end
      else
      begin
         result_written <= 1'b0;
         case (seq_reg)
            SQ_INIT:
            begin
               if (phase_done)
               begin
                  seq_reg <= SQ_SPECIAL;
                  cnt_reg <= 32'(SPECIAL_CYC - 1);
               end
               else
                  cnt_reg <= cnt_reg - 32'h1;
            end
            SQ_SPECIAL:
            begin
               if (phase_done)
               begin
                  seq_reg <= SQ_BRIDGE;
                  cnt_reg <= 32'(BRIDGE_CYC - 1);
                  gap_reg <= 8'h00;
               end
               else
                  cnt_reg <= cnt_reg - 32'h1;
            end
            SQ_BRIDGE:
            begin
               if (phase_done)
               begin
                  result_written <= 1'b1;
                  due_reg <= (gap_reg == special_gap(rate_sel));
                  gap_reg <= gap_reg + 8'h1;
                  // mode choice; power down after request
                  if (sleep_mode)
                     seq_reg <= SQ_IDLE;
                  else if (rate_sel == 2'h0)
                  begin
                     seq_reg <= (gap_reg == special_gap(rate_sel)) ? SQ_SPECIAL : SQ_BRIDGE;
                     cnt_reg <= (gap_reg == special_gap(rate_sel)) ? 32'(SPECIAL_CYC - 1) : 32'(BRIDGE_CYC - 1);
                  end
                  else
                  begin
                     seq_reg <= SQ_SLEEP;
                     cnt_reg <= sleep_len(rate_sel);
                  end
               end
               else
                  cnt_reg <= cnt_reg - 32'h1;
            end
            SQ_SLEEP:
            begin
               if (phase_done)
               begin
                  seq_reg <= due_reg ? SQ_SPECIAL : SQ_BRIDGE;
                  cnt_reg <= due_reg ? 32'(SPECIAL_CYC - 1) : 32'(BRIDGE_CYC - 1);
               end
               else
                  cnt_reg <= cnt_reg - 32'h1;
            end
            SQ_IDLE:
            begin
               // stay down until a request; full set; bridge only
               // response is special plus bridge, or bridge alone
               if (!sleep_mode || (wake && !req_full_reg))
               begin
                  seq_reg <= SQ_BRIDGE;
                  cnt_reg <= 32'(BRIDGE_CYC - 1);
               end
               else if (wake)
               begin
                  seq_reg <= SQ_SPECIAL;
                  cnt_reg <= 32'(SPECIAL_CYC - 1);
               end
            end
            default:
            begin
               seq_reg <= SQ_INIT;
               cnt_reg <= 32'(INIT_CYC - 1);
            end
         endcase
      end
   end

   assign conv_special = seq_reg[1];
   assign conv_bridge = seq_reg[2];
   assign powered_down = seq_reg[3] | seq_reg[4];

   // ************************************************
   // Output register and freshness
   // ************************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         zero_reg <= 14'h0000;
         temp_reg <= 11'h000;
         out_bridge_reg <= 14'h0000;
         out_temp_reg <= 11'h000;
         fresh_reg <= 1'b0;
      end
      else
      begin
         if ((seq_reg == SQ_SPECIAL) && phase_done)
         begin
            zero_reg <= adc_zero;
            temp_reg <= adc_temp;
         end
         // correction uses stored zero and temperature
         if ((seq_reg == SQ_BRIDGE) && phase_done)
         begin
            out_bridge_reg <= adc_bridge - zero_reg;
            out_temp_reg <= temp_reg;
         end
         // fresh only after a write; pressure-only result also valid
         if ((seq_reg == SQ_BRIDGE) && phase_done)
            fresh_reg <= 1'b1;
         // completed fetch marks stale, a new result wins
         else if (fetch_done_reg)
            fresh_reg <= 1'b0;
      end
   end

   assign result_fresh = fresh_reg;

   // status encoding; stale while a requested cycle runs
   always_comb
   begin
      if (diag_fault)
         status_now = ST_FAULT;
      else if (sleep_mode && (seq_reg != SQ_IDLE))
         status_now = ST_STALE;
      else if (!fresh_reg)
         status_now = ST_STALE;
      else
         status_now = ST_FRESH;
   end

   // ************************************************
   // Pin synchronisers and bus events
   // ************************************************
   // A level counts only once the second and third stages agree
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         scl_s_reg <= SYNC_RESET;
         sda_s_reg <= SYNC_RESET;
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
         scl_p_reg <= 1'b1;
         sda_p_reg <= 1'b1;
      end
      else
      begin
         scl_s_reg <= {scl_s_reg[1:0], scl_i};
         sda_s_reg <= {sda_s_reg[1:0], sda_i};
         if (scl_s_reg[1] == scl_s_reg[2])
            scl_f_reg <= scl_s_reg[2];
         if (sda_s_reg[1] == sda_s_reg[2])
            sda_f_reg <= sda_s_reg[2];
         scl_p_reg <= scl_f_reg;
         sda_p_reg <= sda_f_reg;
      end
   end

   assign start_ev = scl_f_reg && scl_p_reg && sda_p_reg && !sda_f_reg;
   assign stop_ev = scl_f_reg && scl_p_reg && !sda_p_reg && sda_f_reg;
   assign scl_rise = scl_f_reg && !scl_p_reg;
   assign scl_fall = !scl_f_reg && scl_p_reg;

   // ************************************************
   // Serial target
   // ************************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ic_reg <= IC_IDLE;
         bit_reg <= 4'h0;
         rx_reg <= 8'h00;
         rw_reg <= 1'b0;
         hit_reg <= 1'b0;
         sent_reg <= 1'b0;
         stale_pkt_reg <= 1'b0;
         poison_reg <= 1'b0;
         seen_reg <= 1'b0;
         drive_reg <= 1'b0;
         tx_reg <= '0;
         req_full_reg <= 1'b0;
         req_press_reg <= 1'b0;
         fetch_done_reg <= 1'b0;
      end
      else
      begin
         fetch_done_reg <= 1'b0;
         if (wake || !sleep_mode)
         begin
            req_full_reg <= 1'b0;
            req_press_reg <= 1'b0;
         end
         if (start_ev)
         begin
            // no SDA rise before the first SCL rise is expected here
            seen_reg <= 1'b0;
            hit_reg <= 1'b0;
            sent_reg <= 1'b0;
            bit_reg <= 4'h0;
            drive_reg <= 1'b0;
            // repeated start poisons the next transaction
            if ((ic_reg != IC_IDLE) && (ic_reg != IC_SKIP))
            begin
               poison_reg <= 1'b1;
               ic_reg <= IC_SKIP;
            end
            // poisoned transaction fails, a further start recovers
            else if (poison_reg)
            begin
               poison_reg <= 1'b0;
               ic_reg <= IC_SKIP;
            end
            else
               ic_reg <= IC_ADDR;
         end
         else if (stop_ev)
         begin
            if (!seen_reg)
               poison_reg <= 1'b1;
            ic_reg <= IC_IDLE;
            drive_reg <= 1'b0;
            hit_reg <= 1'b0;
            // fetch ends here; bare read or stale read is a request
            if (hit_reg && rw_reg)
            begin
               fetch_done_reg <= sent_reg;
               if (!sent_reg || stale_pkt_reg)
                  req_full_reg <= 1'b1;
            end
            if (hit_reg && !rw_reg)
               req_press_reg <= 1'b1;
         end
         else if (scl_rise)
         begin
            seen_reg <= 1'b1;
            if (ic_reg == IC_ADDR)
            begin
               rx_reg <= {rx_reg[6:0], sda_f_reg};
               bit_reg <= bit_reg + 4'h1;
            end
            else if ((ic_reg == IC_MACK) && sda_f_reg)
               ic_reg <= IC_SKIP;
         end
         else if (scl_fall)
         begin
            case (ic_reg)
               IC_ADDR:
               begin
                  if ((bit_reg == BITS_PER_BYTE) && (rx_reg[7:1] == DEV_ADDR))
                  begin
                     ic_reg <= IC_AACK;
                     drive_reg <= 1'b1;
                     rw_reg <= rx_reg[0];
                     hit_reg <= 1'b1;
                     tx_reg <= '{status: status_now, bridge: out_bridge_reg, temp: out_temp_reg, pad: 5'h00};
                     // A stale read while busy must not queue a second measurement
                     stale_pkt_reg <= (status_now != ST_FRESH) && (seq_reg == SQ_IDLE);
                  end
                  else if (bit_reg == BITS_PER_BYTE)
                     ic_reg <= IC_SKIP;
               end
               IC_AACK, IC_MACK:
               begin
                  if (rw_reg)
                  begin
                     ic_reg <= IC_TX;
                     drive_reg <= !tx_reg[31];
                     tx_reg <= {tx_reg[30:0], 1'b1};
                     bit_reg <= 4'h1;
                  end
                  else
                  begin
                     ic_reg <= IC_SKIP;
                     drive_reg <= 1'b0;
                  end
               end
               IC_TX:
               begin
                  if (bit_reg == BITS_PER_BYTE)
                  begin
                     ic_reg <= IC_MACK;
                     drive_reg <= 1'b0;
                     sent_reg <= 1'b1;
                  end
                  else
                  begin
                     drive_reg <= !tx_reg[31];
                     tx_reg <= {tx_reg[30:0], 1'b1};
                     bit_reg <= bit_reg + 4'h1;
                  end
               end
               default:
                  drive_reg <= 1'b0;
            endcase
         end
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_n = !drive_reg;

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic [31:0] age_reg;
   logic first_seen_reg;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         age_reg <= 32'h0;
         first_seen_reg <= 1'b0;
      end
      else
      begin
         if (age_reg != 32'hFFFFFFFF)
            age_reg <= age_reg + 32'h1;
         if (result_written)
            first_seen_reg <= 1'b1;
      end
   end

   chk_init_to_special: assert property ((seq_reg == SQ_INIT) && phase_done |=> seq_reg == SQ_SPECIAL)
      else $error("init did not start conversions");
   chk_first_result: assert property (result_written && !first_seen_reg && !sleep_mode
      |-> age_reg <= 32'(FIRST_RESULT_CYC))
      else $error("first result too late");
   chk_rate0_nosleep: assert property (!sleep_mode && (rate_sel == 2'h0) && (seq_reg == SQ_BRIDGE)
      |=> seq_reg != SQ_SLEEP)
      else $error("rate 0 powered down");
   chk_sleep_len: assert property ($rose(seq_reg == SQ_SLEEP) |-> cnt_reg == sleep_len(rate_sel))
      else $error("wrong power-down length");
   chk_special_bridge: assert property ((seq_reg == SQ_SPECIAL) && phase_done
      |=> (seq_reg == SQ_BRIDGE) && (cnt_reg == 32'(BRIDGE_CYC - 1)))
      else $error("special not followed by bridge");
   chk_idle_holds: assert property (sleep_mode && (seq_reg == SQ_IDLE) && !req_full_reg && !req_press_reg
      |=> seq_reg == SQ_IDLE)
      else $error("woke without request");
   chk_full_request: assert property (wake && req_full_reg |=> seq_reg == SQ_SPECIAL)
      else $error("full request skipped special");
   chk_press_request: assert property (wake && !req_full_reg |=> seq_reg == SQ_BRIDGE)
      else $error("pressure request not bridge only");
   chk_write_fresh: assert property (result_written |-> result_fresh ##1 (result_fresh || $past(fetch_done_reg)))
      else $error("result not marked fresh");
   chk_fetch_stale: assert property (fetch_done_reg && !result_written && !((seq_reg == SQ_BRIDGE) && phase_done)
      |=> !result_fresh)
      else $error("fetch left data fresh");
   chk_busy_stale: assert property (sleep_mode && !diag_fault && (seq_reg != SQ_IDLE) |-> status_now == ST_STALE)
      else $error("busy fetch not stale");
   chk_fault_code: assert property (diag_fault |-> status_now == ST_FAULT)
      else $error("fault code missing");
   chk_poison_fail: assert property (start_ev && poison_reg && (ic_reg == IC_IDLE)
      |=> (ic_reg == IC_SKIP) && !poison_reg)
      else $error("poisoned transaction answered");

   cov_full_req: cover property (wake && req_full_reg);
   cov_press_req: cover property (wake && req_press_reg && !req_full_reg);
   cov_fetch: cover property (fetch_done_reg ##1 !result_fresh);
   cov_poison: cover property (start_ev && poison_reg);
endmodule // psq_sequencer

/* core/psq_pkg.sv */
// Constants and types for the pressure measurement sequencer.
// Assumes a 100 MHz core clock; all cycle counts derive from it.
package psq_pkg;
   localparam int CLK_MHZ = 100;
   localparam int INIT_TIME_US = 1500;
   localparam int SPECIAL_TIME_US = 800;
   localparam int BRIDGE_TIME_US = 500;
   localparam int FIRST_RESULT_US = 2800;
   localparam int PERIOD0_US = 500;
   localparam int PERIOD1_US = 1500;
   localparam int PERIOD2_US = 6500;
   localparam int PERIOD3_US = 32000;
   localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
   localparam int SPECIAL_CYCLES = SPECIAL_TIME_US * CLK_MHZ;
   localparam int BRIDGE_CYCLES = BRIDGE_TIME_US * CLK_MHZ;
   localparam int FIRST_RESULT_CYCLES = FIRST_RESULT_US * CLK_MHZ;
   // Power-down fills the update period left over after the bridge conversion
   localparam int SLEEP1_CYCLES = (PERIOD1_US - BRIDGE_TIME_US) * CLK_MHZ;
   localparam int SLEEP2_CYCLES = (PERIOD2_US - BRIDGE_TIME_US) * CLK_MHZ;
   localparam int SLEEP3_CYCLES = (PERIOD3_US - BRIDGE_TIME_US) * CLK_MHZ;
   localparam logic [7:0] GAP_RATE0 = 8'hFF;
   localparam logic [7:0] GAP_RATE1 = 8'h7F;
   localparam logic [7:0] GAP_RATE2 = 8'h1F;
   localparam logic [7:0] GAP_RATE3 = 8'h0F;
   localparam logic [1:0] ST_FRESH = 2'h0;
   localparam logic [1:0] ST_INVALID = 2'h1;
   localparam logic [1:0] ST_STALE = 2'h2;
   localparam logic [1:0] ST_FAULT = 2'h3;
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h50;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [2:0] SYNC_RESET = 3'h7;

   typedef struct packed
   {
      logic [1:0] status;
      logic [13:0] bridge;
      logic [10:0] temp;
      logic [4:0] pad;
   } psq_packet_t;

   typedef enum logic [4:0]
   {
      SQ_INIT = 5'b00001,
      SQ_SPECIAL = 5'b00010,
      SQ_BRIDGE = 5'b00100,
      SQ_SLEEP = 5'b01000,
      SQ_IDLE = 5'b10000
   } psq_seq_t;

   typedef enum logic [5:0]
   {
      IC_IDLE = 6'b000001,
      IC_ADDR = 6'b000010,
      IC_AACK = 6'b000100,
      IC_TX = 6'b001000,
      IC_MACK = 6'b010000,
      IC_SKIP = 6'b100000
   } psq_i2c_t;
endpackage

/* dv/psq_i2c_ctrl.sv */
// Serial bus controller model facing the sensor's target port.
// Assumes the bench resolves SDA from both enables with a pull-up.
module psq_i2c_ctrl
   import psq_pkg::*;
(
   output logic scl, // Serial clock, still between frames
   output logic oe_n, // Low while pulling SDA low
   input wire logic sda // Resolved SDA level
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rx;
   event rx_ev;
   // Bus released and clock parked high; only the caller's process drives
   task automatic idle();
      scl = 1'b1;
      oe_n = 1'b1;
   endtask
   task automatic tell(input logic [7:0] v);
      rx = v;
      ->rx_ev;
   endtask
   // SDA pulled low with the clock high, then the clock falls 62.5 ns later
   task automatic start();
      oe_n = 1'b0;
      #62.5 scl = 1'b0;
   endtask
   // Bus free time kept after every stop
   task automatic stop();
      #31 oe_n = 1'b0;
      #31.5 scl = 1'b1;
      #62.5 oe_n = 1'b1;
      #2000;
   endtask
   // Data moves mid-low so the target never sees it race the clock edge
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rv);
      for (int i = 8; i >= 0; i--)
      begin
         #31 oe_n = tx[i];
         #31.5 scl = 1'b1;
         #62.5 rv[i] = sda;
         scl = 1'b0;
      end
   endtask
   // Request is address and direction, then stop
   task automatic request(input logic rd);
      logic [8:0] r;
      start();
      xfer({DEV_ADDR_DEFAULT, rd, 1'b1}, r);
      tell({7'h00, r[0]});
      stop();
   endtask
   // Fetch of n bytes, NACK on the last
   task automatic fetch(input int n);
      logic [8:0] r;
      start();
      xfer({DEV_ADDR_DEFAULT, 2'h3}, r);
      tell({7'h00, r[0]});
      for (int i = 0; i < n && !r[0]; i++)
      begin
         xfer({8'hFF, i == n - 1}, r);
         tell(r[8:1]);
      end
      stop();
   endtask
   // Start then stop with no clock pulse
   task automatic glitch();
      oe_n = 1'b0;
      #62.5 oe_n = 1'b1;
      #2000;
   endtask
endmodule // psq_i2c_ctrl

/* dv/test_pressure_sensor_measure_sequencer.sv */
// Self-checking bench for the measurement sequencer and its serial port.
// Assumes the controller model in psq_i2c_ctrl and short phase lengths.
module test_pressure_sensor_measure_sequencer
   import psq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BR = 8;
   localparam int FR = 1100;
   int sl[4] = '{0, 6, 12, 3000};
   logic clk;
   logic rst;
   logic sleep_mode;
   logic diag_fault;
   logic [1:0] rate_sel;
   logic [13:0] adc_bridge;
   logic [13:0] adc_zero;
   logic [10:0] adc_temp;
   logic [13:0] ex_b, ex_z;
   logic [10:0] ex_t;
   logic scl;
   logic sda;
   logic ctl_oe_n;
   logic dut_oe_n;
   logic dut_sda_o;
   logic conv_special;
   logic conv_bridge;
   logic powered_down;
   logic result_written;
   logic result_fresh;
   logic [7:0] exp_q[$];
   int spec;
   int s0;
   int bad_count = 0, comparisons = 0, n;
   // Open drain with pull-up: the target pulls to its drive value while enabled
   assign sda = ctl_oe_n & (dut_oe_n | dut_sda_o);
   psq_i2c_ctrl ctrl (.scl(scl), .oe_n(ctl_oe_n), .sda(sda));
   psq_sequencer #(.INIT_CYC(20), .SPECIAL_CYC(1000), .BRIDGE_CYC(BR), .SLEEP1_CYC(6), .SLEEP2_CYC(12),
      .SLEEP3_CYC(3000), .FIRST_RESULT_CYC(FR)) uut (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda),
      .sda_o(dut_sda_o), .sda_oe_n(dut_oe_n), .sleep_mode(sleep_mode), .rate_sel(rate_sel),
      .diag_fault(diag_fault), .adc_bridge(adc_bridge), .adc_temp(adc_temp), .adc_zero(adc_zero),
      .conv_special(conv_special), .conv_bridge(conv_bridge), .powered_down(powered_down),
      .result_written(result_written), .result_fresh(result_fresh));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Counts special-phase cycles; scenarios compare against a snapshot
   always @(posedge clk) if (conv_special) spec <= spec + 1;
   task automatic close_out();
      if (exp_q.size() != 0) bad_count++;
      $display("Counts: %0d mismatches, %0d comparisons", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic note(input logic [1:0] st, input int n);
      logic [31:0] p;
      p = {st, 14'(ex_b - ex_z), ex_t, 5'h00};
      exp_q.push_back(8'h00);
      for (int i = 0; i < n; i++) exp_q.push_back(p[31 - 8 * i -: 8]);
   endtask
   task automatic wait_wr(output int c);
      c = 0;
      do
      begin
         @(posedge clk);
         c++;
      end
      while (result_written !== 1'b1 && c < 5000);
      if (c >= 5000)
      begin
         bad_count++;
         close_out();
      end
   endtask
   task automatic new_adc();
      @(posedge clk);
      adc_bridge <= 14'($urandom);
      adc_temp <= 11'($urandom);
      adc_zero <= 14'($urandom);
   endtask
   task automatic do_reset(input logic sm, input logic [1:0] r);
      @(posedge clk);
      rst <= 1'b1;
      sleep_mode <= sm;
      rate_sel <= r;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic take_all();
      ex_b = adc_bridge;
      ex_z = adc_zero;
      ex_t = adc_temp;
   endtask
   // Byte monitor: each received byte is checked against the oldest note
   initial
   begin
      forever
      begin
         @(ctrl.rx_ev);
         cmp(ctrl.rx, exp_q.size() == 0 ? 16'hFFFF : exp_q.pop_front());
      end
   end
   initial
   begin
      ctrl.idle();
      rst <= 1'b1;
      sleep_mode <= 1'b1;
      diag_fault <= 1'b0;
      rate_sel <= 2'h0;
      void'($urandom(32'hC760));
      new_adc();
      do_reset(1'b1, 2'h0);
      wait_wr(n);
      take_all();
      cmp(16'(n >= 1026 && n <= FR), 16'h1);
      repeat (3) @(posedge clk);
      cmp(16'(powered_down), 16'h1);
      note(ST_FRESH, 4);
      ctrl.fetch(4);
      cmp(16'(powered_down), 16'h1);
      cmp(16'(result_fresh), 16'h0);
      new_adc();
      s0 = spec;
      exp_q.push_back(8'h00);
      ctrl.request(1'b0);
      ex_b = adc_bridge;
      note(ST_FRESH, 4);
      ctrl.fetch(4);
      cmp(16'(spec != s0), 16'h0);
      new_adc();
      exp_q.push_back(8'h00);
      ctrl.request(1'b1);
      note(ST_STALE, 2);
      ctrl.fetch(2);
      wait_wr(n);
      take_all();
      cmp(16'(spec != s0), 16'h1);
      note(ST_FRESH, 4);
      ctrl.fetch(4);
      ctrl.glitch();
      exp_q.push_back(8'h01);
      ctrl.fetch(2);
      note(ST_STALE, 2);
      ctrl.fetch(2);
      wait_wr(n);
      diag_fault <= 1'b1;
      note(ST_FAULT, 2);
      ctrl.fetch(2);
      @(posedge clk);
      diag_fault <= 1'b0;
      for (int r = 0; r < 4; r++)
      begin
         do_reset(1'b0, 2'(r));
         wait_wr(n);
         wait_wr(n);
         cmp(16'(n >= BR + sl[r] - 1 && n <= BR + sl[r] + 1), 16'h1);
         cmp(16'({conv_bridge, powered_down}), r == 0 ? 16'h2 : 16'h1);
      end
      wait_wr(n);
      note(ST_FRESH, 2);
      ctrl.fetch(2);
      cmp(16'(result_fresh), 16'h0);
      note(ST_STALE, 2);
      ctrl.fetch(2);
      close_out();
   end
endmodule // test_pressure_sensor_measure_sequencer
